// ### ppm_pkg.sv
/*
  ppm_pkg: constants shared by the port pin function mux.
  assumes: two 8-bit ports, all logic on one system clock.
*/
package ppm_pkg;
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] PULL_HIGH_RESET = 8'h00;
  localparam logic [7:0] INPUT_ENABLE_RESET = 8'hFF;
  localparam logic PULL_LOW_RESET = 1'b0;
  // pin positions of alternate functions
  localparam int PA_CRYSTAL_IN = 7;
  localparam int PA_CRYSTAL_OUT = 6;
  localparam int PA_RESET_PIN = 5;
  localparam int PA_IRQ1_ALT = 4;
  localparam int PA_CMP_PLUS = 4;
  localparam int PA_ADC_NINE = 4;
  localparam int PA_ADC_EIGHT = 3;
  localparam int PA_CMP_MINUS0 = 3;
  localparam int PA_TIMER2_PWM = 3;
  localparam int PA_ADC_TEN = 0;
  localparam int PA_IRQ0 = 0;
  localparam int PA_CMP_OUT = 0;
  localparam int PB_ADC_SEVEN = 7;
  localparam int PB_CMP_MINUS5 = 7;
  localparam int PB_ADC_SIX = 6;
  localparam int PB_CMP_MINUS4 = 6;
  localparam int PB_PULL_LOW = 6;
  // interrupt edge selection
  typedef enum logic [1:0] {
    PPM_EDGE_BOTH,
    PPM_EDGE_RISE,
    PPM_EDGE_FALL,
    PPM_EDGE_NONE
  } ppm_edge_type;
endpackage

// ### ppm_edge_detect.sv
/*
  ppm_edge_detect: synchroniser and edge detector for one pin input.
  assumes: pin is asynchronous; clock enable freezes all state.
*/
`timescale 1ns/10ps
`default_nettype none
module ppm_edge_detect
(
  input wire logic clock, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic enable, // clock enable
  input wire logic pin, // asynchronous pin level
  input wire logic gate, // input buffer enabled
  output logic level, // synchronised, gated level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic [2:0] settle;
  } ppm_sync_state_type;

  ppm_sync_state_type state;
  ppm_sync_state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.meta = pin;
    next_state.sync = state.meta;
    // disabled buffer reads low and produces no edges
    next_state.last = state.sync & gate;
    // edges count only once last holds a real sample after reset
    next_state.settle = {state.settle[1:0], 1'b1};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state <= '0;
    end
    else if (enable)
    begin
      state <= next_state;
    end
  end

  assign level = state.last;
  assign rise = enable & gate & state.settle[2] & state.sync & ~state.last;
  assign fall = enable & gate & state.settle[2] & ~state.sync & state.last;
endmodule // ppm_edge_detect
`default_nettype wire

// ### ppm_port_mux.sv
/*
  ppm_port_mux: routes port A and port B pins between general I/O and
  alternate functions (crystal, reset pin, ADC, comparator, PWM, irqs).
  assumes: pads resolve pin levels from output enables and pull enables;
  analog signals are routed by pad switches driven from the selects here.
*/
// Contract
// - pins are input or output, pull-high each
// - input enable zero kills buffer and wake-up
// - port A bit 0 wake-up blocked; the mux still wakes on PA0 edges
// - external irq on selectable rise/fall edge
// - PA0 feeds irq0, PA4 alternate irq1
// - PA5 open-drain, pull-high, optional reset input
// - ADC channels ten..six map to pins
// - comparator inputs and output mapped to pins
// - timer2 PWM on PA3, timer3 on PB7/PB6
// - PB6 has separate pull-low resistor
`timescale 1ns/10ps
`default_nettype none
module ppm_port_mux
#(
  parameter int WIDTH = ppm_pkg::PORT_WIDTH
)
(
  input wire logic clock, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic enable, // clock enable
  input wire logic [WIDTH-1:0] pa_in, // port A pin levels
  output logic [WIDTH-1:0] pa_out, // port A pin output value
  output logic [WIDTH-1:0] pa_oe, // port A pin output enable
  output logic [WIDTH-1:0] pa_pull_high, // port A pull-high enable
  input wire logic [WIDTH-1:0] pb_in, // port B pin levels
  output logic [WIDTH-1:0] pb_out, // port B pin output value
  output logic [WIDTH-1:0] pb_oe, // port B pin output enable
  output logic [WIDTH-1:0] pb_pull_high, // port B pull-high enable
  output logic pb_pull_low, // PB6 pull-low enable
  input wire logic cfg_write, // load configuration below
  input wire logic [WIDTH-1:0] cfg_pa_dir, // port A output directions
  input wire logic [WIDTH-1:0] cfg_pa_data, // port A output data
  input wire logic [WIDTH-1:0] cfg_pa_pull_high, // port A pull-high
  input wire logic [WIDTH-1:0] cfg_pa_input_enable, // port A input enable
  input wire logic [WIDTH-1:0] cfg_pb_dir, // port B output directions
  input wire logic [WIDTH-1:0] cfg_pb_data, // port B output data
  input wire logic [WIDTH-1:0] cfg_pb_pull_high, // port B pull-high
  input wire logic [WIDTH-1:0] cfg_pb_input_enable, // port B input enable
  input wire logic cfg_pb_pull_low, // PB6 pull-low
  input wire logic cfg_reset_pin_en, // PA5 acts as hardware reset
  input wire logic cfg_crystal_en, // PA7/PA6 used by crystal
  input wire logic cfg_irq1_alt_sel, // irq1 from PA4
  input wire logic [1:0] cfg_irq0_edge, // irq0 edge select
  input wire logic [1:0] cfg_irq1_edge, // irq1 edge select
  input wire logic cfg_cmp_out_en, // comparator output on PA0
  input wire logic cfg_timer2_pwm_en, // timer2 PWM on PA3
  input wire logic [1:0] cfg_timer3_pwm_en, // timer3 PWM on PB7, PB6
  input wire logic irq1_main_in, // irq1 main source level, synced
  input wire logic comparator_output, // comparator result
  input wire logic second_timer_pwm_out, // timer2 PWM
  input wire logic third_timer_pwm_out, // timer3 PWM
  input wire logic [4:0] adc_select, // ADC channel number
  input wire logic [2:0] cmp_minus_select, // comparator minus source
  output logic [WIDTH-1:0] pa_read, // port A data as read by core
  output logic [WIDTH-1:0] pb_read, // port B data as read by core
  output logic wake_up, // pin toggle wake-up pulse
  output logic ext_irq_line0, // irq0 request pulse
  output logic ext_irq_line1_alt, // irq1 request pulse, from PA4 or the main source
  output logic hardware_reset_pin, // reset request, active high
  output logic crystal_in, // crystal input pad switch
  output logic crystal_out, // crystal output pad switch
  output logic adc_channel_ten, // PA0 analog switch
  output logic adc_channel_nine, // PA4 analog switch
  output logic adc_channel_eight, // PA3 analog switch
  output logic adc_channel_seven, // PB7 analog switch
  output logic adc_channel_six, // PB6 analog switch
  output logic comparator_plus_input, // PA4 to plus input switch
  output logic comparator_minus_src0, // PA3 minus switch
  output logic comparator_minus_src1, // PA4 minus switch
  output logic comparator_minus_src4, // PB6 minus switch
  output logic comparator_minus_src5 // PB7 minus switch
);
  typedef struct packed {
    logic [WIDTH-1:0] pa_dir;
    logic [WIDTH-1:0] pa_data;
    logic [WIDTH-1:0] pa_pull_high;
    logic [WIDTH-1:0] pa_ie;
    logic [WIDTH-1:0] pb_dir;
    logic [WIDTH-1:0] pb_data;
    logic [WIDTH-1:0] pb_pull_high;
    logic [WIDTH-1:0] pb_ie;
    logic pb_pull_low;
    logic reset_pin_en;
    logic crystal_en;
    logic irq1_alt_sel;
    logic [1:0] irq0_edge;
    logic [1:0] irq1_edge;
    logic cmp_out_en;
    logic timer2_pwm_en;
    logic [1:0] timer3_pwm_en;
    logic [WIDTH-1:0] pa_out;
    logic [WIDTH-1:0] pa_oe;
    logic [WIDTH-1:0] pb_out;
    logic [WIDTH-1:0] pb_oe;
    logic irq0;
    logic irq1;
    logic wake;
    logic reset_req;
    logic reset_arm;
    logic irq1_main_last;
  } ppm_state_type;

  ppm_state_type state;
  ppm_state_type next_state;
  logic [WIDTH-1:0] pa_level;
  logic [WIDTH-1:0] pa_rise;
  logic [WIDTH-1:0] pa_fall;
  logic [WIDTH-1:0] pb_level;
  logic [WIDTH-1:0] pb_rise;
  logic [WIDTH-1:0] pb_fall;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pins
      ppm_edge_detect u_pa
      (
        .clock(clock),
        .rst_b(rst_b),
        .enable(enable),
        .pin(pa_in[i]),
        .gate(state.pa_ie[i]),
        .level(pa_level[i]),
        .rise(pa_rise[i]),
        .fall(pa_fall[i])
      );
      ppm_edge_detect u_pb
      (
        .clock(clock),
        .rst_b(rst_b),
        .enable(enable),
        .pin(pb_in[i]),
        .gate(state.pb_ie[i]),
        .level(pb_level[i]),
        .rise(pb_rise[i]),
        .fall(pb_fall[i])
      );
    end
  endgenerate

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise_ev,
                                    input logic fall_ev);
    logic hit;
    hit = 1'b0;
    case (sel)
      ppm_pkg::PPM_EDGE_BOTH: hit = rise_ev | fall_ev;
      ppm_pkg::PPM_EDGE_RISE: hit = rise_ev;
      ppm_pkg::PPM_EDGE_FALL: hit = fall_ev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  always_comb
  begin
    logic irq1_rise;
    logic irq1_fall;
    next_state = state;
    irq1_rise = 1'b0;
    irq1_fall = 1'b0;
    if (cfg_write)
    begin
      next_state.pa_dir = cfg_pa_dir;
      next_state.pa_data = cfg_pa_data;
      next_state.pa_pull_high = cfg_pa_pull_high;
      next_state.pa_ie = cfg_pa_input_enable;
      next_state.pb_dir = cfg_pb_dir;
      next_state.pb_data = cfg_pb_data;
      next_state.pb_pull_high = cfg_pb_pull_high;
      next_state.pb_ie = cfg_pb_input_enable;
      next_state.pb_pull_low = cfg_pb_pull_low;
      next_state.reset_pin_en = cfg_reset_pin_en;
      next_state.crystal_en = cfg_crystal_en;
      next_state.irq1_alt_sel = cfg_irq1_alt_sel;
      next_state.irq0_edge = cfg_irq0_edge;
      next_state.irq1_edge = cfg_irq1_edge;
      next_state.cmp_out_en = cfg_cmp_out_en;
      next_state.timer2_pwm_en = cfg_timer2_pwm_en;
      next_state.timer3_pwm_en = cfg_timer3_pwm_en;
    end
    // general I/O: data and direction straight from configuration
    next_state.pa_out = state.pa_data;
    next_state.pa_oe = state.pa_dir;
    next_state.pb_out = state.pb_data;
    next_state.pb_oe = state.pb_dir;
    // PA5 open drain: drive low only
    next_state.pa_out[ppm_pkg::PA_RESET_PIN] = 1'b0;
    next_state.pa_oe[ppm_pkg::PA_RESET_PIN] =
      state.pa_dir[ppm_pkg::PA_RESET_PIN]
      & ~state.pa_data[ppm_pkg::PA_RESET_PIN]
      & ~state.reset_pin_en;
    // crystal pads released here; their input buffers are software's job
    if (state.crystal_en)
    begin
      next_state.pa_oe[ppm_pkg::PA_CRYSTAL_IN] = 1'b0;
      next_state.pa_oe[ppm_pkg::PA_CRYSTAL_OUT] = 1'b0;
    end
    // alternate outputs take the pad over from general I/O
    if (state.cmp_out_en)
    begin
      next_state.pa_out[ppm_pkg::PA_CMP_OUT] = comparator_output;
      next_state.pa_oe[ppm_pkg::PA_CMP_OUT] = 1'b1;
    end
    if (state.timer2_pwm_en)
    begin
      next_state.pa_out[ppm_pkg::PA_TIMER2_PWM] =
        second_timer_pwm_out;
      next_state.pa_oe[ppm_pkg::PA_TIMER2_PWM] = 1'b1;
    end
    if (state.timer3_pwm_en[1])
    begin
      next_state.pb_out[ppm_pkg::PB_ADC_SEVEN] =
        third_timer_pwm_out;
      next_state.pb_oe[ppm_pkg::PB_ADC_SEVEN] = 1'b1;
    end
    if (state.timer3_pwm_en[0])
    begin
      next_state.pb_out[ppm_pkg::PB_ADC_SIX] = third_timer_pwm_out;
      next_state.pb_oe[ppm_pkg::PB_ADC_SIX] = 1'b1;
    end
    // interrupt line 0 from PA0, line 1 from PA4 or main source
    next_state.irq0 = edge_hit(state.irq0_edge,
      pa_rise[ppm_pkg::PA_IRQ0], pa_fall[ppm_pkg::PA_IRQ0]);
    next_state.irq1_main_last = irq1_main_in;
    if (state.irq1_alt_sel)
    begin
      irq1_rise = pa_rise[ppm_pkg::PA_IRQ1_ALT];
      irq1_fall = pa_fall[ppm_pkg::PA_IRQ1_ALT];
    end
    else
    begin
      irq1_rise = irq1_main_in & ~state.irq1_main_last;
      irq1_fall = ~irq1_main_in & state.irq1_main_last;
    end
    next_state.irq1 = edge_hit(state.irq1_edge, irq1_rise, irq1_fall);
    // wake-up only from pins whose input buffer is on
    next_state.wake = |{pa_rise, pa_fall, pb_rise, pb_fall};
    // reset pin is active low on the pad; armed a cycle after its buffer
    // turns on, so the stale low of a just-enabled buffer is no reset
    next_state.reset_arm = state.reset_pin_en
      & state.pa_ie[ppm_pkg::PA_RESET_PIN];
    next_state.reset_req = state.reset_arm
      & ~pa_level[ppm_pkg::PA_RESET_PIN];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state <= '0;
      state.pa_dir <= ppm_pkg::DIR_RESET;
      state.pa_data <= ppm_pkg::DATA_RESET;
      state.pa_pull_high <= ppm_pkg::PULL_HIGH_RESET;
      state.pa_ie <= ppm_pkg::INPUT_ENABLE_RESET;
      state.pb_dir <= ppm_pkg::DIR_RESET;
      state.pb_data <= ppm_pkg::DATA_RESET;
      state.pb_pull_high <= ppm_pkg::PULL_HIGH_RESET;
      state.pb_ie <= ppm_pkg::INPUT_ENABLE_RESET;
      state.pb_pull_low <= ppm_pkg::PULL_LOW_RESET;
    end
    else if (enable)
    begin
      state <= next_state;
    end
  end

  assign pa_out = state.pa_out;
  assign pa_oe = state.pa_oe;
  assign pa_pull_high = state.pa_pull_high;
  assign pb_out = state.pb_out;
  assign pb_oe = state.pb_oe;
  assign pb_pull_high = state.pb_pull_high;
  assign pb_pull_low = state.pb_pull_low;
  assign pa_read = pa_level;
  assign pb_read = pb_level;
  assign wake_up = state.wake;
  assign ext_irq_line0 = state.irq0;
  assign ext_irq_line1_alt = state.irq1;
  assign hardware_reset_pin = state.reset_req;
  assign crystal_in = state.crystal_en;
  assign crystal_out = state.crystal_en;
  // analog switches follow the selected channel numbers; comparator plus switch is always on
  assign adc_channel_ten = (adc_select == 5'h0A);
  assign adc_channel_nine = (adc_select == 5'h09);
  assign adc_channel_eight = (adc_select == 5'h08);
  assign adc_channel_seven = (adc_select == 5'h07);
  assign adc_channel_six = (adc_select == 5'h06);
  assign comparator_plus_input = 1'b1;
  assign comparator_minus_src0 = (cmp_minus_select == 3'h0);
  assign comparator_minus_src1 = (cmp_minus_select == 3'h1);
  assign comparator_minus_src4 = (cmp_minus_select == 3'h4);
  assign comparator_minus_src5 = (cmp_minus_select == 3'h5);
endmodule // ppm_port_mux
`default_nettype wire

// ### ppm_port_mux_properties.sv
/*
  ppm_port_mux_properties: port-level timing checks for ppm_port_mux.
  assumes: bound into every ppm_port_mux; one clock, sync active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ppm_port_mux_properties
(
  input wire logic clock, // clock
  input wire logic rst_b, // reset
  input wire logic enable, // run
  input wire logic [7:0] pa_in, // pins
  input wire logic [7:0] pa_out, // pad value
  input wire logic [7:0] pa_oe, // pad drive
  input wire logic [7:0] pb_out, // pad value
  input wire logic [7:0] pb_oe, // pad drive
  input wire logic pb_pull_low, // pull-low
  input wire logic [7:0] pa_read, // read
  input wire logic [7:0] pb_read, // read
  input wire logic hardware_reset_pin, // reset out
  input wire logic ext_irq_line0, // irq0
  input wire logic cfg_write, // load
  input wire logic [7:0] cfg_pa_input_enable, // enables
  input wire logic [7:0] cfg_pb_input_enable, // enables
  input wire logic cfg_reset_pin_en, // cfg
  input wire logic cfg_cmp_out_en, // cfg
  input wire logic cfg_timer2_pwm_en, // cfg
  input wire logic [1:0] cfg_timer3_pwm_en, // cfg
  input wire logic cfg_pb_pull_low, // cfg
  input wire logic [1:0] cfg_irq0_edge, // cfg
  input wire logic comparator_output, // core
  input wire logic second_timer_pwm_out, // core
  input wire logic third_timer_pwm_out // core
);
  logic [23:0] cin;
  logic [23:0] h1;
  logic [23:0] h2;
  logic [23:0] h3;
  logic s;
  // loaded config history; checks wait until three samples agree
  assign cin = {cfg_pa_input_enable, cfg_pb_input_enable, cfg_reset_pin_en,
    cfg_cmp_out_en, cfg_timer2_pwm_en, cfg_timer3_pwm_en, cfg_pb_pull_low,
    cfg_irq0_edge};
  assign s = (h1 == h2) && (h2 == h3);
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      h1 <= {16'hFFFF, 8'h00};
      h2 <= {16'hFFFF, 8'h00};
      h3 <= {16'hFFFF, 8'h00};
    end
    else if (enable)
    begin
      if (cfg_write)
        h1 <= cin;
      h2 <= h1;
      h3 <= h2;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  read_gate_a: assert property (s |-> ((pa_read & ~h3[23:16]) |
    (pb_read & ~h3[15:8])) == 8'h00) else $error("read while disabled");
  open_drain_a: assert property (!pa_out[5] &&
    !(s && h3[7] && pa_oe[5])) else $error("PA5 driven high");
  reset_input_a: assert property ((s && enable && h3[7] && h3[21] &&
    !pa_in[5])[*5] |-> hardware_reset_pin) else $error("reset not seen");
  reset_off_a: assert property (s && !h3[7] |-> !hardware_reset_pin)
    else $error("reset while deselected");
  cmp_drive_a: assert property ((s && enable && h3[6] &&
    $stable(comparator_output))[*3] |-> pa_oe[0] &&
    pa_out[0] == comparator_output) else $error("comparator not on PA0");
  pwm2_drive_a: assert property ((s && enable && h3[5] &&
    $stable(second_timer_pwm_out))[*3] |-> pa_oe[3] &&
    pa_out[3] == second_timer_pwm_out) else $error("pwm2 not on PA3");
  pwm3_drive_a: assert property ((s && enable && h3[4:3] == 2'h3 &&
    $stable(third_timer_pwm_out))[*3] |-> pb_oe[7:6] == 2'h3 &&
    pb_out[7:6] == {2{third_timer_pwm_out}}) else $error("pwm3 not on PB");
  pull_low_a: assert property (s |-> pb_pull_low == h3[2])
    else $error("pull-low differs");
  edge_none_a: assert property (s && h3[1:0] == 2'h3 |->
    !ext_irq_line0) else $error("irq0 while off");
endmodule // ppm_port_mux_properties
bind ppm_port_mux ppm_port_mux_properties i_props (.*);
`default_nettype wire

// ### ppm_pins.sv
/*
  ppm_pins: board side of one 8-bit port; resolves each pin level.
  assumes: pad drive wins over board drive; lone pins float.
*/
`timescale 1ns/10ps
`default_nettype none
module ppm_pins
(
  input wire logic clock, // pattern clock
  input wire logic [7:0] out, // pad value
  input wire logic [7:0] oe, // pad drives
  input wire logic [7:0] pull_high, // pull-high on
  input wire logic [7:0] pull_low, // pull-low on
  input wire logic [7:0] ext_val, // board value
  input wire logic [7:0] ext_en, // board drives
  output logic [7:0] pin // resolved level
);
  logic [7:0] last = 8'h00;
  // a floating pin shows the inverse of its last level
  assign pin = (oe & out) | (~oe & ext_en & ext_val) |
    (~oe & ~ext_en & (pull_high | (~pull_low & ~last)));
  always_ff @(posedge clock)
    last <= pin;
endmodule // ppm_pins
`default_nettype wire

// ### tb.sv
/*
  tb: self-checking bench for ppm_port_mux with board pin models.
  assumes: inputs change at falling edges; config loads settle in 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock = 1'h0, rst_b = 1'h0, enable = 1'h1, cfg_write = 1'h0;
  logic cfg_pb_pull_low = 1'h0, cfg_reset_pin_en = 1'h0, cfg_crystal_en = 1'h0;
  logic cfg_irq1_alt_sel = 1'h0, cfg_cmp_out_en = 1'h0, irq1_main_in = 1'h0;
  logic cfg_timer2_pwm_en = 1'h0, comparator_output = 1'h0;
  logic second_timer_pwm_out = 1'h0, third_timer_pwm_out = 1'h0;
  logic [1:0] cfg_irq0_edge = 2'h0, cfg_irq1_edge = 2'h0;
  logic [1:0] cfg_timer3_pwm_en = 2'h0;
  logic [4:0] adc_select = 5'h00;
  logic [2:0] cmp_minus_select = 3'h0;
  logic [7:0] cfg_pa_dir = 8'h00, cfg_pa_data = 8'h00;
  logic [7:0] cfg_pa_pull_high = 8'h00;
  logic [7:0] cfg_pb_dir = 8'h00, cfg_pb_data = 8'h00;
  logic [7:0] cfg_pb_pull_high = 8'h00;
  logic [7:0] cfg_pa_input_enable = 8'hFF, cfg_pb_input_enable = 8'hFF;
  logic [7:0] pa_ext = 8'h00, pa_ext_en = 8'h31;
  wire logic [7:0] pa_in, pa_out, pa_oe, pa_pull_high, pa_read;
  wire logic [7:0] pb_in, pb_out, pb_oe, pb_pull_high, pb_read;
  wire logic pb_pull_low, wake_up, ext_irq_line0, ext_irq_line1_alt;
  wire logic hardware_reset_pin, crystal_in, crystal_out;
  wire logic adc_channel_ten, adc_channel_nine, adc_channel_eight;
  wire logic adc_channel_seven, adc_channel_six, comparator_plus_input;
  wire logic comparator_minus_src0, comparator_minus_src1;
  wire logic comparator_minus_src4, comparator_minus_src5;
  int err_total = 0, n_checks = 0, cyc = 0, n_irq0 = 0, n_irq1 = 0, n_wake = 0;
  int c0, c1;
  ppm_port_mux i_dut (.*);
  ppm_pins i_pa (.clock(clock), .out(pa_out), .oe(pa_oe),
    .pull_high(pa_pull_high), .pull_low(8'h00), .ext_val(pa_ext),
    .ext_en(pa_ext_en), .pin(pa_in));
  ppm_pins i_pb (.clock(clock), .out(pb_out), .oe(pb_oe),
    .pull_high(pb_pull_high), .pull_low({1'h0, pb_pull_low, 6'h00}),
    .ext_val(8'h00), .ext_en(8'h00), .pin(pb_in));
  always #5 clock = ~clock;
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // event pulse counters and hang guard
  always @(posedge clock)
  begin
    n_irq0 += ext_irq_line0;
    n_irq1 += ext_irq_line1_alt;
    n_wake += wake_up;
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task load;
    cfg_write = 1'h1;
    tick(1);
    cfg_write = 1'h0;
    tick(4);
  endtask
  task pin_a(input int b, input logic v);
    pa_ext[b] = v;
    tick(6);
  endtask
  initial
  begin
    tick(3);
    rst_b = 1'h1;
    tick(1);
    chk(pb_pull_low, 0);
    chk(pa_oe, 8'h00);
    cfg_pa_dir = 8'h26;
    cfg_pa_data = 8'h04;
    cfg_pa_pull_high = 8'h28;
    cfg_pa_input_enable = 8'h19;
    cfg_pb_input_enable = 8'h00;
    load();
    chk(pa_oe, 8'h26);
    chk({pa_in[2:1], pa_pull_high}, 10'h228);
    chk({pa_read[3], pa_read[2:1]}, 3'h4);
    // board lets go of PA5 so that only the pull-high holds it
    pa_ext_en[5] = 1'h0;
    cfg_pa_data = 8'h24;
    load();
    chk({pa_oe[5], pa_in[5]}, 2'h1);
    for (int e = 0; e < 4; e++)
    begin
      cfg_irq0_edge = e[1:0];
      load();
      c0 = n_irq0;
      pin_a(0, 1'h1);
      pin_a(0, 1'h0);
      chk(n_irq0 - c0, (e == 3) ? 0 : (e == 0) ? 2 : 1);
    end
    cfg_irq0_edge = 2'h0;
    load();
    c0 = n_wake;
    pin_a(0, 1'h1);
    chk(n_wake - c0, 1);
    cfg_pa_input_enable = 8'h18;
    load();
    c0 = n_wake;
    c1 = n_irq0;
    pin_a(0, 1'h0);
    pin_a(0, 1'h1);
    chk(n_wake - c0, 0);
    chk(n_irq0 - c1, 0);
    chk(pa_read[0], 0);
    cfg_irq1_alt_sel = 1'h1;
    load();
    c0 = n_irq1;
    pin_a(4, 1'h1);
    pin_a(4, 1'h0);
    chk(n_irq1 - c0, 2);
    enable = 1'h0;
    pin_a(4, 1'h1);
    chk(n_irq1 - c0, 2);
    enable = 1'h1;
    // software clears the crystal pins' input enables
    cfg_pa_input_enable = 8'h20;
    cfg_reset_pin_en = 1'h1;
    cfg_crystal_en = 1'h1;
    pa_ext_en[5] = 1'h1;
    cfg_pa_dir = 8'hE6;
    cfg_pa_data = 8'h00;
    load();
    chk({pa_oe, crystal_in, crystal_out}, 10'h01B);
    chk(hardware_reset_pin, 1);
    pin_a(5, 1'h1);
    chk(hardware_reset_pin, 0);
    cfg_reset_pin_en = 1'h0;
    cfg_crystal_en = 1'h0;
    cfg_cmp_out_en = 1'h1;
    cfg_timer2_pwm_en = 1'h1;
    cfg_timer3_pwm_en = 2'h3;
    cfg_pb_pull_low = 1'h1;
    cfg_pb_pull_high = 8'h40;
    cfg_pb_dir = 8'h01;
    cfg_pb_data = 8'h01;
    load();
    chk({pb_pull_low, pb_pull_high, pb_oe[0], pb_out[0]}, 11'h503);
    for (int v = 0; v < 2; v++)
    begin
      comparator_output = v[0];
      second_timer_pwm_out = ~v[0];
      third_timer_pwm_out = v[0];
      tick(4);
      chk({pa_out[0], pa_out[3], pb_out[7:6]},
        {v[0], ~v[0], {2{v[0]}}});
    end
    cfg_pb_pull_high = 8'h00;
    cfg_pb_input_enable = 8'h40;
    cfg_timer3_pwm_en = 2'h0;
    cfg_irq1_alt_sel = 1'h0;
    cfg_irq1_edge = 2'h1;
    load();
    chk({pb_in[6], pb_read[6]}, 2'h0);
    // main irq1 source, rising edge only
    c0 = n_irq1;
    irq1_main_in = 1'h1;
    tick(4);
    irq1_main_in = 1'h0;
    tick(4);
    chk(n_irq1 - c0, 1);
    for (int i = 0; i < 32; i++)
    begin
      adc_select = i[4:0];
      cmp_minus_select = i[2:0];
      tick(1);
      chk({adc_channel_ten, adc_channel_nine, adc_channel_eight,
        adc_channel_seven, adc_channel_six}, {i == 10, i == 9, i == 8,
        i == 7, i == 6});
      chk({comparator_plus_input, comparator_minus_src0,
        comparator_minus_src1, comparator_minus_src4, comparator_minus_src5},
        {1'h1, i[2:0] == 3'h0, i[2:0] == 3'h1, i[2:0] == 3'h4,
        i[2:0] == 3'h5});
    end
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
